// ---- hdl/gio_pkg.sv ----
// Purpose: Constants and carrier types for the general digital I/O port.
// Assumes: One 8-pin port, classic Wishbone slave with 32-bit data.
// Notes:   Registers sit in the low byte; upper bits read as zero.
package gio_pkg;

  localparam int unsigned NPINS = 8;
  localparam int unsigned ADR_W = 4;
  localparam int unsigned DAT_W = 32;

  localparam logic [ADR_W-1:0] OFS_PIN  = 4'h0;
  localparam logic [ADR_W-1:0] OFS_DIR  = 4'h4;
  localparam logic [ADR_W-1:0] OFS_OUT  = 4'h8;
  localparam logic [ADR_W-1:0] OFS_CTRL = 4'hc;

  localparam int unsigned CTRL_PUD_BIT   = 0;
  localparam int unsigned CTRL_SLEEP_BIT = 1;

  localparam logic [NPINS-1:0] RST_DIR = 8'h00;
  localparam logic [NPINS-1:0] RST_OUT = 8'h00;
  localparam logic             RST_PUD = 1'b0;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [3:0]       sel;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
  } gio_wb_req_s;

  typedef struct packed {
    logic [NPINS-1:0] en;
    logic [NPINS-1:0] edge_cfg;
  } gio_extint_s;

  typedef struct packed {
    logic [NPINS-1:0] dir;
    logic [NPINS-1:0] outv;
    logic             global_pullup_disable;
    logic             ack;
    logic [DAT_W-1:0] rdat;
    logic [NPINS-1:0] oe;
    logic [NPINS-1:0] drv;
    logic [NPINS-1:0] pull;
    logic             sleep_q;
    logic [NPINS-1:0] seen_high;
    logic [NPINS-1:0] wake;
  } gio_state_s;

endpackage

// ---- hdl/gio_sync.sv ----
// Purpose: Pin input synchronizer, clock-high latch then rising-edge register.
// Assumes: i_clk is the system clock; i_d may change at any time.
// Notes:   Half-cycle latch stage keeps pin-to-register delay to 0.5..1.5 periods.
`timescale 1ns/1ns
module gio_sync (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic [gio_pkg::NPINS-1:0] i_d,
  output logic      [gio_pkg::NPINS-1:0] o_q
);

  logic [gio_pkg::NPINS-1:0] lat;

  // Transparent while clock high, closes on the falling edge
  // Nonblocking, so the register takes the level held since the last fall
  always_latch begin
    if (i_clk) begin
      lat <= i_d;
    end
  end

  // Only the register reads the latch
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_q <= '0;
    end else begin
      o_q <= lat;
    end
  end

endmodule

// ---- hdl/gio_port.sv ----
// Purpose: Eight-pin general digital I/O port behind a Wishbone slave.
// Assumes: Sleep and external interrupt controls come from logic on I_REF_CLK.
// Notes:   Pin outputs are registered; the pad resolves level from enables.
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
module gio_port (
  input  wire logic                      I_REF_CLK,
  input  wire logic                      I_RESETN,
  input  wire logic                      I_WB_CYC,
  input  wire logic                      I_WB_STB,
  input  wire logic                      I_WB_WE,
  input  wire logic [3:0]                I_WB_SEL,
  input  wire logic [gio_pkg::ADR_W-1:0] I_WB_ADR,
  input  wire logic [gio_pkg::DAT_W-1:0] I_WB_DAT,
  output logic      [gio_pkg::DAT_W-1:0] O_WB_DAT,
  output logic                           O_WB_ACK,
  input  wire logic [gio_pkg::NPINS-1:0] I_PIN_IN,
  output logic      [gio_pkg::NPINS-1:0] O_PIN_OUT,
  output logic      [gio_pkg::NPINS-1:0] O_PIN_OE,
  output logic      [gio_pkg::NPINS-1:0] O_PULLUP_EN,
  input  wire logic                      I_SLEEP,
  input  wire logic [gio_pkg::NPINS-1:0] I_EXTINT_EN,
  input  wire logic [gio_pkg::NPINS-1:0] I_EXTINT_EDGE,
  output logic      [gio_pkg::NPINS-1:0] O_WAKE_FLAG_SET
);

  gio_pkg::gio_state_s  st;
  gio_pkg::gio_state_s  next_st;
  gio_pkg::gio_wb_req_s req;
  gio_pkg::gio_extint_s ext;

  logic [gio_pkg::NPINS-1:0] clamp;
  logic [gio_pkg::NPINS-1:0] pin_gated;
  logic [gio_pkg::NPINS-1:0] pin_sync;
  logic [gio_pkg::NPINS-1:0] raw_sync;
  logic [gio_pkg::NPINS-1:0] edge_idle;
  logic                      bus_req;
  logic                      wr;
  logic [gio_pkg::DAT_W-1:0] rd_mux;

  function automatic logic hit(input logic [gio_pkg::ADR_W-1:0] adr,
                               input logic [gio_pkg::ADR_W-1:0] ofs);
    hit = (adr == ofs);
  endfunction

  function automatic logic [gio_pkg::DAT_W-1:0] zext(input logic [gio_pkg::NPINS-1:0] v);
    zext = {24'h000000, v};
  endfunction

  assign req.cyc = I_WB_CYC;
  assign req.stb = I_WB_STB;
  assign req.we  = I_WB_WE;
  assign req.sel = I_WB_SEL;
  assign req.adr = I_WB_ADR;
  assign req.dat = I_WB_DAT;

  assign ext.en       = I_EXTINT_EN;
  assign ext.edge_cfg = I_EXTINT_EDGE;

  // Floating inputs in deep sleep would burn current, so gate ahead of sync
  assign clamp     = {gio_pkg::NPINS{I_SLEEP}} & ~ext.en;
  assign pin_gated = I_PIN_IN & ~clamp;

  gio_sync u_sync_pin (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RESETN),
    .i_d     (pin_gated),
    .o_q     (pin_sync)
  );

  // Unclamped copy watches idle interrupt pins during sleep
  gio_sync u_sync_raw (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RESETN),
    .i_d     (I_PIN_IN),
    .o_q     (raw_sync)
  );

  assign edge_idle = ext.edge_cfg & ~ext.en;
  assign bus_req   = req.cyc & req.stb;
  // One write strobe set for the whole port, taken at the acknowledging edge
  assign wr        = bus_req & req.we & st.ack & req.sel[0];

  always_comb begin
    rd_mux = '0;
    if (hit(req.adr, gio_pkg::OFS_PIN)) begin
      rd_mux = zext(pin_sync);
    end else if (hit(req.adr, gio_pkg::OFS_DIR)) begin
      rd_mux = zext(st.dir);
    end else if (hit(req.adr, gio_pkg::OFS_OUT)) begin
      rd_mux = zext(st.outv);
    end else if (hit(req.adr, gio_pkg::OFS_CTRL)) begin
      rd_mux[gio_pkg::CTRL_PUD_BIT]   = st.global_pullup_disable;
      rd_mux[gio_pkg::CTRL_SLEEP_BIT] = I_SLEEP;
    end
  end

  always_comb begin
    next_st     = st;
    next_st.ack = bus_req & ~st.ack;
    // Read data frozen at the edge that raises ack so it is stable at the taking edge
    if (bus_req && !st.ack) begin
      next_st.rdat = rd_mux;
    end
    if (wr && hit(req.adr, gio_pkg::OFS_DIR)) begin
      next_st.dir = req.dat[gio_pkg::NPINS-1:0];
    end
    if (wr && hit(req.adr, gio_pkg::OFS_OUT)) begin
      next_st.outv = req.dat[gio_pkg::NPINS-1:0];
    end
    // Input register holds no storage; ones flip the value bits, zeros leave them
    if (wr && hit(req.adr, gio_pkg::OFS_PIN)) begin
      next_st.outv = st.outv ^ req.dat[gio_pkg::NPINS-1:0];
    end
    if (wr && hit(req.adr, gio_pkg::OFS_CTRL)) begin
      next_st.global_pullup_disable = req.dat[gio_pkg::CTRL_PUD_BIT];
    end
    // Pad controls follow the register update in the same edge
    next_st.oe   = next_st.dir;
    next_st.drv  = next_st.outv;
    next_st.pull = ~next_st.dir & next_st.outv & {gio_pkg::NPINS{~next_st.global_pullup_disable}};
    next_st.sleep_q = I_SLEEP;
    if (I_SLEEP) begin
      next_st.seen_high = st.seen_high | (raw_sync & edge_idle);
    end else begin
      next_st.seen_high = '0;
    end
    // Sleep released: idle edge pins seen high during sleep, or high now, set the wake flag
    if (st.sleep_q && !I_SLEEP) begin
      next_st.wake = (st.seen_high | raw_sync) & edge_idle;
    end else begin
      next_st.wake = '0;
    end
  end

  // Async clear empties drive and pull-up with no clock running
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st           <= '0;
      st.dir       <= gio_pkg::RST_DIR;
      st.outv      <= gio_pkg::RST_OUT;
      st.global_pullup_disable       <= gio_pkg::RST_PUD;
    end else begin
      st <= next_st;
    end
  end

  assign O_WB_DAT        = st.rdat;
  assign O_WB_ACK        = st.ack;
  assign O_PIN_OE        = st.oe;
  // Looped-back level reaches the input register one period after the write
  assign O_PIN_OUT       = st.drv;
  assign O_PULLUP_EN     = st.pull;
  assign O_WAKE_FLAG_SET = st.wake;

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RESETN);

  sequence s_write(logic [gio_pkg::ADR_W-1:0] ofs);
    I_WB_CYC && I_WB_STB && I_WB_WE && I_WB_SEL[0] && O_WB_ACK && I_WB_ADR == ofs;
  endsequence

  sequence s_read_pin;
    I_WB_CYC && I_WB_STB && !I_WB_WE && !O_WB_ACK && I_WB_ADR == gio_pkg::OFS_PIN
      ##1 O_WB_ACK;
  endsequence

  property p_dir_write;
    s_write(gio_pkg::OFS_DIR) |=> O_PIN_OE == $past(I_WB_DAT[7:0]);
  endproperty

  a_dir_sets_oe: assert property (p_dir_write)
    else $error("direction write not reflected on output enable");

  a_pullup_input_one: assert property (
    (O_PIN_OE == 8'h00 && !st.global_pullup_disable) |-> O_PULLUP_EN == O_PIN_OUT)
    else $error("pull-up missing on input with value one");

  a_pullup_off_cases: assert property (
    (O_PULLUP_EN & (O_PIN_OE | ~O_PIN_OUT)) == 8'h00)
    else $error("pull-up on for output or value zero");

  a_pud_kills_pullup: assert property (
    s_write(gio_pkg::OFS_CTRL) ##0 I_WB_DAT[gio_pkg::CTRL_PUD_BIT]
      |=> (O_PULLUP_EN == 8'h00) [*2])
    else $error("pull-up active with global disable set");

  a_reset_tristate: assert property (
    disable iff (1'b0) !I_RESETN |-> (O_PIN_OE == 8'h00 && O_PULLUP_EN == 8'h00))
    else $error("pins not tri-stated during reset");

  a_reset_no_pullup: assert property (
    disable iff (1'b0) $rose(I_RESETN) |-> O_PULLUP_EN == 8'h00)
    else $error("pull-up active at reset release");

  a_output_level: assert property (
    s_write(gio_pkg::OFS_OUT) |=> (O_PIN_OUT & O_PIN_OE) == ($past(I_WB_DAT[7:0]) & O_PIN_OE))
    else $error("output pin does not drive value bit");

  a_toggle_ones: assert property (
    s_write(gio_pkg::OFS_PIN) |=> O_PIN_OUT == ($past(O_PIN_OUT) ^ $past(I_WB_DAT[7:0])))
    else $error("input-bit write did not toggle value");

  a_toggle_zero_hold: assert property (
    s_write(gio_pkg::OFS_PIN) ##0 I_WB_DAT[7:0] == 8'h00 |=> $stable(O_PIN_OUT))
    else $error("zero write to input bits changed value");

  a_pin_readback: assert property (s_read_pin |-> O_WB_DAT == {24'h000000, $past(pin_sync)})
    else $error("input register read does not return pin level");

  a_sync_delay: assert property (
    ($stable(pin_gated)) [*3] |-> pin_sync == pin_gated)
    else $error("stable pin not visible after synchronizer");

  a_sleep_clamp: assert property (
    ($stable(clamp) && I_SLEEP) [*3] |-> (pin_sync & clamp) == 8'h00)
    else $error("clamped pin seen high in sleep");

  a_wake_flag_cause: assert property (
    O_WAKE_FLAG_SET != 8'h00 |-> $past(st.sleep_q) && !$past(I_SLEEP)
      && (O_WAKE_FLAG_SET & ~$past(edge_idle)) == 8'h00)
    else $error("wake flag set without wake or on enabled pin");

  a_ack_single: assert property (
    (I_WB_CYC && I_WB_STB && !O_WB_ACK) |=> O_WB_ACK ##1 !O_WB_ACK)
    else $error("ack not a single cycle after request");

endmodule

// ---- test/gio_pad_model.sv ----
// Purpose: Pads and outside circuitry of the eight port pins.
// Assumes: Port driver beats outside driver, outside beats pull-up.
// Notes:   A pad left open moves every cycle.
`timescale 1ns/1ns
module gio_pad_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_pull,
  input  wire logic [7:0] i_ext_en,
  input  wire logic [7:0] i_ext_val,
  output logic      [7:0] o_pad
);
  logic [7:0] flt = 8'h55;
  // Open pad has no fixed level
  always @(posedge i_clk) flt <= ~flt;
  assign o_pad = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
               | (~i_oe & ~i_ext_en & (i_pull | flt));
endmodule

// ---- test/testbench.sv ----
// Purpose: Self-checking bench for the general digital I/O port.
// Assumes: Pad levels come from the pad model.
// Notes:   One task per scenario.
`timescale 1ns/1ns
module testbench;
  logic        clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        sleep;
  logic        ack;
  logic [3:0]  adr;
  logic [3:0]  sel;
  logic [3:0]  wsel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [7:0]  pad, oe, pout, pull, wake, xen, xval, ien, iedge, seen;
  int          mismatches;
  int          total_checks;

  gio_port DUT (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_SEL(sel), .I_WB_ADR(adr), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_PIN_IN(pad), .O_PIN_OUT(pout), .O_PIN_OE(oe),
    .O_PULLUP_EN(pull), .I_SLEEP(sleep), .I_EXTINT_EN(ien), .I_EXTINT_EDGE(iedge),
    .O_WAKE_FLAG_SET(wake));
  gio_pad_model pads (.i_clk(clk), .i_oe(oe), .i_out(pout), .i_pull(pull),
    .i_ext_en(xen), .i_ext_val(xval), .o_pad(pad));

  task automatic final_report;
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    total_checks++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, seen_v, exp_v);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= wsel;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic t_config;
    wr(4'h8, 32'hcc);
    tick();
    chk(32'(pull), 32'hcc);
    wr(4'h4, 32'hf0);
    tick();
    chk(32'(oe), 32'hf0);
    chk(32'(pout & oe), 32'hc0);
    chk(32'(pull), 32'h0c);
    wr(4'hc, 32'h1);
    tick();
    chk(32'(pull), 32'h0);
    rd(4'hc, 32'h1);
    wr(4'hc, 32'h0);
    rd(4'h0, 32'hc5);
    rd(4'h2, 32'h0);
  endtask

  task automatic t_toggle;
    wr(4'h0, 32'h3c);
    rd(4'h0, 32'hf5);
    tick();
    chk(32'(pout), 32'hf0);
    wr(4'h0, 32'h0);
    // Byte lane zero off: the write is acked but must not land
    wsel = 4'h0;
    wr(4'h8, 32'h0);
    wsel = 4'h1;
    rd(4'h8, 32'hf0);
    rd(4'h4, 32'hf0);
    rd(4'h0, 32'hf5);
  endtask

  task automatic t_reset;
    wr(4'h4, 32'h0);
    tick();
    chk(32'(pull), 32'hf0);
    // Pulled low just after an edge: clearing before the next edge needs no clock
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    chk(32'(pull), 32'h0);
    chk(32'(oe | pout), 32'h0);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tick();
  endtask

  task automatic t_sleep;
    @(posedge clk);
    xen <= 8'hff;
    xval <= 8'hff;
    ien <= 8'h0f;
    iedge <= 8'hf0;
    sleep <= 1'b1;
    repeat (3) @(posedge clk);
    rd(4'h0, 32'h0f);
    rd(4'hc, 32'h2);
    sleep <= 1'b0;
    seen = 8'h00;
    repeat (6) begin
      tick();
      seen = seen | wake;
    end
    chk(32'(seen), 32'hf0);
    rd(4'h0, 32'hff);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    wsel = 4'h1;
    sleep = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    xen = 8'h0f;
    xval = 8'h05;
    ien = 8'h00;
    iedge = 8'h00;
    mismatches = 0;
    total_checks = 0;
    repeat (10) @(posedge clk);
    #1;
    chk(32'(oe | pull), 32'h0);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_config();
    t_toggle();
    t_reset();
    t_sleep();
    final_report();
  end
endmodule
